// File: async_timer_pkg.sv
/*
 Shared constants and carriers for the asynchronous event counter/timer.
 Assumes one system clock at CLK_HZ and control bits held steady by the owner.
*/
package async_timer_pkg;
	// System clock rate and the internal instruction clock divider (Fosc/4)
	localparam int CLK_HZ = 20000000;
	localparam int INSTR_DIV = 4;
	// Oscillator rating and the least samples per source period we need
	localparam int OSC_MAX_HZ = 200000;
	localparam int MIN_SAMPLES = 4;
	localparam int OSC_SAMPLES = CLK_HZ / OSC_MAX_HZ;
	// Counter width and reset value of the count
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
	localparam logic [2:0] PRESC_RESET = 3'h0;
	localparam logic [1:0] DIV_RESET = 2'h0;
	localparam logic [1:0] DIV_LAST = 2'h3;

	// Timer control: bit 0 run, 1 external clock, 2 sync disable, 3 osc enable, 5:4 prescale
	typedef struct packed {
		logic [1:0] unused;
		logic [1:0] prescale;
		logic osc_enable_bit;
		logic sync_disable_bit;
		logic clock_select;
		logic timer_on;
	} timer_control_t;

	// One byte write toward the count
	typedef struct packed {
		logic low_we;
		logic high_we;
		logic [7:0] data;
	} count_write_t;
endpackage : async_timer_pkg

// File: async_event_counter_timer.sv
/*
 16-bit timer/counter with prescaler, synchronised and unsynchronised external
 counting, and a built-in low-power crystal amplifier.
 Assumes all pins are synchronous to sys_clk and software holds the control bits.
*/
// Functional notes
// - Sync-disable bit bypasses the clock synchroniser
// - Unsynchronised counter advances on external edges only
// - Unsynchronised counting survives sleep, overflow wakes
// - No capture/compare time base when unsynchronised
// - Count bytes read stable from registers
// - Write colliding with increment: write wins
// - Osc-enable bit turns on crystal amplifier
// - Compare trigger reset ignored when unsynchronised
// - Any count byte write clears prescaler
`timescale 1ns/1ps
module async_event_counter_timer #(
	parameter int COUNT_W = async_timer_pkg::COUNT_W,
	parameter int INSTR_DIV = async_timer_pkg::INSTR_DIV
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control and power state
	input wire async_timer_pkg::timer_control_t timer_control_reg,
	input wire logic sleep_mode,
	// Count access
	input wire async_timer_pkg::count_write_t count_write,
	input wire logic overflow_clear,
	output logic [7:0] count_low_byte,
	output logic [7:0] count_high_byte,
	// Clock source pins
	input wire logic ext_clk_pin,
	input wire logic crystal_in_pin,
	output logic crystal_out_pin,
	// Capture/compare unit side
	input wire logic special_event_trigger,
	output logic [15:0] time_base,
	output logic time_base_valid,
	// Events
	output logic overflow_flag,
	output logic wake_request
);
	// rating check
	// Sampling a 200 kHz source needs several clocks per period
	initial begin
		if (COUNT_W != 16 || INSTR_DIV != 4 ||
				async_timer_pkg::OSC_SAMPLES < async_timer_pkg::MIN_SAMPLES) begin
			$error("Unsupported counter parameters");
		end
	end

	// Registered state
	logic [15:0] count; // The count itself, read as two bytes
	logic [2:0] presc; // Prescaler counter
	logic [1:0] div; // Instruction clock divider
	logic raw_q; // Direct sample for the unsynchronised path
	logic raw_d; // Previous direct sample
	logic sync1; // Synchroniser first stage
	logic sync2; // Synchroniser second stage
	logic sync3; // Edge history of the synchronised path
	logic xout; // Crystal amplifier output

	// Next values
	logic [15:0] next_count;
	logic [2:0] next_presc;
	logic [1:0] next_div;
	logic next_raw_q;
	logic next_raw_d;
	logic next_sync1;
	logic next_sync2;
	logic next_sync3;
	logic next_xout;
	logic next_flag;

	// Decoded helpers
	logic src; // Selected external source level
	logic async_mode; // External clock, not synchronised
	logic instr_tick; // Internal instruction clock enable
	logic source_tick; // Edge reaching the prescaler
	logic count_tick; // Prescaled increment
	logic [2:0] presc_mask;
	logic any_write;
	logic trig_reset;
	logic wrap;

	// Decode modes, edges and prescaler terminal count
	always_comb begin
		// crystal source select
		// With the oscillator on, the crystal input feeds the counter
		src = timer_control_reg.osc_enable_bit ? crystal_in_pin : ext_clk_pin;
		async_mode = timer_control_reg.clock_select & timer_control_reg.sync_disable_bit;
		instr_tick = (div == async_timer_pkg::DIV_LAST) & ~sleep_mode;
		any_write = count_write.low_we | count_write.high_we;
		case (timer_control_reg.prescale)
			2'h0: presc_mask = 3'h0;
			2'h1: presc_mask = 3'h1;
			2'h2: presc_mask = 3'h3;
			2'h3: presc_mask = 3'h7;
			default: presc_mask = 3'h0;
		endcase
		if (!timer_control_reg.clock_select) begin
			// Timer mode: instruction clock, halted in sleep
			source_tick = instr_tick;
		end else if (async_mode) begin
			// no sleep gating here, the edge alone advances the count
			source_tick = raw_q & ~raw_d;
		end else begin
			// Synchronised counting stops with the phase clocks in sleep
			source_tick = sync2 & ~sync3 & ~sleep_mode;
		end
		source_tick = source_tick & timer_control_reg.timer_on;
		// only the external edge path clocks the unsynchronised count
		count_tick = source_tick & ((presc & presc_mask) == presc_mask);
		// trigger reset honoured only in synchronised modes
		trig_reset = special_event_trigger & ~async_mode;
	end

	// Next state of the counter, prescaler and flag
	always_comb begin
		next_raw_q = src;
		next_raw_d = raw_q;
		next_sync1 = src;
		next_sync2 = sync1;
		next_sync3 = sync2;
		next_xout = timer_control_reg.osc_enable_bit & ~crystal_in_pin;
		next_div = (div == async_timer_pkg::DIV_LAST) ? async_timer_pkg::DIV_RESET : div + 2'h1;
		next_count = count;
		wrap = 1'b0;
		if (any_write) begin
			next_presc = async_timer_pkg::PRESC_RESET;
		end else if (source_tick) begin
			next_presc = presc + 3'h1;
		end else begin
			next_presc = presc;
		end
		// write takes precedence over a colliding increment
		if (any_write) begin
			if (count_write.low_we) begin
				next_count[7:0] = count_write.data;
			end
			if (count_write.high_we) begin
				next_count[15:8] = count_write.data;
			end
		end else if (trig_reset) begin
			next_count = async_timer_pkg::COUNT_RESET;
		end else if (count_tick) begin
			next_count = count + 16'h0001;
			wrap = (count == async_timer_pkg::COUNT_ALL_ONES);
		end
		next_flag = wrap | (overflow_flag & ~overflow_clear);
	end

	// Register all state; the count powers up at a defined zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= async_timer_pkg::COUNT_RESET;
			presc <= async_timer_pkg::PRESC_RESET;
			div <= async_timer_pkg::DIV_RESET;
			raw_q <= 1'b0;
			raw_d <= 1'b0;
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			xout <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			count <= next_count;
			presc <= next_presc;
			div <= next_div;
			raw_q <= next_raw_q;
			raw_d <= next_raw_d;
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
			xout <= next_xout;
			overflow_flag <= next_flag;
		end
	end

	// bytes straight from the count register
	assign count_low_byte = count[7:0];
	assign count_high_byte = count[15:8];
	assign crystal_out_pin = xout;
	assign time_base = count;
	assign time_base_valid = timer_control_reg.timer_on & ~async_mode;
	assign wake_request = overflow_flag & sleep_mode;

	a_overflow_wrap: assert property (@(posedge sys_clk) disable iff (rst)
		count_tick && count == 16'hFFFF && !any_write && !trig_reset
		|=> count == 16'h0000 && overflow_flag)
		else $error("Wrap did not clear count and set flag");

	a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
		count_tick && !any_write && !trig_reset |=> count == $past(count) + 16'h0001)
		else $error("Count did not step by one");

	a_write_wins: assert property (@(posedge sys_clk) disable iff (rst)
		count_write.low_we && !count_write.high_we
		|=> count[7:0] == $past(count_write.data) && count[15:8] == $past(count[15:8]))
		else $error("Low byte write lost");

	a_presc_clear: assert property (@(posedge sys_clk) disable iff (rst)
		any_write |=> presc == 3'h0)
		else $error("Prescaler not cleared by write");

	a_no_timebase: assert property (@(posedge sys_clk) disable iff (rst)
		timer_control_reg.clock_select && timer_control_reg.sync_disable_bit |-> !time_base_valid)
		else $error("Time base offered in unsynchronised mode");

	a_trig_ignored: assert property (@(posedge sys_clk) disable iff (rst)
		special_event_trigger && async_mode && !any_write && !count_tick
		|=> count == $past(count))
		else $error("Trigger reset acted in unsynchronised mode");

	a_sleep_hold: assert property (@(posedge sys_clk) disable iff (rst)
		sleep_mode && !async_mode && !any_write && !special_event_trigger
		|=> count == $past(count))
		else $error("Count moved in sleep while synchronised");

	// unsynchronised count follows the pin edge within three clocks
	a_async_edge: assert property (@(posedge sys_clk) disable iff (rst)
		async_mode && timer_control_reg.timer_on && !timer_control_reg.osc_enable_bit &&
		timer_control_reg.prescale == 2'h0 && !any_write && !ext_clk_pin ##1 ext_clk_pin
		##1 (!any_write && async_mode) |=> count == $past(count, 2) + 16'h0001)
		else $error("Unsynchronised edge not counted");

	// amplifier idle when oscillator is off
	a_osc_off: assert property (@(posedge sys_clk) disable iff (rst)
		!timer_control_reg.osc_enable_bit |=> !crystal_out_pin)
		else $error("Amplifier driven while disabled");

	a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
		wrap && overflow_clear |=> overflow_flag)
		else $error("Overflow lost to clear");
endmodule : async_event_counter_timer

// File: clock_source_model.sv
/*
 Behavioural far side of the counter: an external count clock and a crystal.
 Assumes the bench starts a burst only while the model reports idle.
*/
`timescale 1ns/1ps
module clock_source_model #(
	parameter int HALF = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Burst request
	input wire logic start,
	input wire logic use_crystal,
	input wire logic [7:0] pulses,
	// Source pins and status
	output logic ext_clk_pin,
	output logic crystal_in_pin,
	output logic busy
);
	logic [7:0] left; // Pulses still to send
	int ph; // Phase within one period
	// Pins rest low between bursts, so no stray edge reaches the counter
	assign busy = (left != 8'h00);
	assign ext_clk_pin = busy && !use_crystal && (ph < HALF);
	assign crystal_in_pin = busy && use_crystal && (ph < HALF);
	// Burst sequencer: HALF cycles high then HALF low, keeps the pulse spacing
	always @(posedge sys_clk) begin
		if (rst) begin
			left <= 8'h00;
			ph <= 0;
		end else if (start && !busy) begin
			left <= pulses;
			ph <= 0;
		end else if (busy) begin
			ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
			if (ph == 2 * HALF - 1)
				left <= left - 8'h01;
		end
	end
endmodule : clock_source_model

// File: async_event_counter_timer_tb.sv
/*
 Self-checking bench for the asynchronous counter/timer.
 Assumes the clock source model drives the pins; notes are checked at falling edges.
*/
`timescale 1ns/1ps
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module async_event_counter_timer_tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	async_timer_pkg::timer_control_t ctl = 8'h00; // Control bits
	async_timer_pkg::count_write_t cw = 10'h000; // Byte writes
	logic sleep = 1'b0, ovc = 1'b0, trig = 1'b0, start = 1'b0, use_x = 1'b0, obs = 1'b0;
	logic [7:0] npulse = 8'h00;
	logic [7:0] lo, hi, d;
	logic [15:0] tbase;
	logic xo, flag, wake, tbv, xi, ext, busy;
	typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic flag, wake, tbv, xo;} note_t;
	note_t notes[$];
	note_t n;
	int fail_count = 0;
	int checked = 0;
	int seed = 37707;
	async_event_counter_timer async_event_counter_timer_inst (.sys_clk(sys_clk), .rst(rst),
		.timer_control_reg(ctl), .sleep_mode(sleep), .count_write(cw), .overflow_clear(ovc),
		.count_low_byte(lo), .count_high_byte(hi), .ext_clk_pin(ext), .crystal_in_pin(xi),
		.crystal_out_pin(xo), .special_event_trigger(trig), .time_base(tbase),
		.time_base_valid(tbv), .overflow_flag(flag), .wake_request(wake));
	clock_source_model clock_source_model_inst (.sys_clk(sys_clk), .rst(rst), .start(start),
		.use_crystal(use_x), .pulses(npulse), .ext_clk_pin(ext), .crystal_in_pin(xi), .busy(busy));
	// Clock at 50 ns period
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// Watcher: takes the oldest note when a result is flagged
	always @(negedge sys_clk) begin
		if (obs === 1'b1) begin
			n = notes.pop_front();
			`CHECK({hi, lo}, {n.hi, n.lo})
			`CHECK(tbase, {n.hi, n.lo})
			`CHECK(flag, n.flag)
			`CHECK(wake, n.wake)
			`CHECK(tbv, n.tbv)
			`CHECK(xo, n.xo)
		end
	end
	task automatic print_verdict();
		$display("counts: checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	// Note an expected result and flag it for one cycle
	task automatic expect_now(input note_t e);
		notes.push_back(e);
		@(posedge sys_clk) obs <= 1'b1;
		@(posedge sys_clk) obs <= 1'b0;
	endtask : expect_now
	task automatic wr(input logic l, input logic h, input logic [7:0] v);
		@(posedge sys_clk) cw <= {l, h, v};
		@(posedge sys_clk) cw <= 10'h000;
	endtask : wr
	// Burst of source pulses, bounded wait for the model to finish
	task automatic pulse(input logic [7:0] k, input logic xtal);
		int i;
		@(posedge sys_clk) begin
			start <= 1'b1;
			use_x <= xtal;
			npulse <= k;
		end
		@(posedge sys_clk) start <= 1'b0;
		// The model takes the burst on this edge, so busy is only seen one edge later
		@(posedge sys_clk);
		for (i = 0; i < 3000 && busy === 1'b1; i++)
			@(posedge sys_clk);
		if (i == 3000) begin
			fail_count++;
			print_verdict();
		end
		repeat (4) @(posedge sys_clk);
	endtask : pulse
	// Pulse the trigger (1) or the overflow clear (0) for one cycle
	task automatic strobe(input logic to_trig);
		@(posedge sys_clk) begin
			if (to_trig)
				trig <= 1'b1;
			else
				ovc <= 1'b1;
		end
		@(posedge sys_clk) begin
			trig <= 1'b0;
			ovc <= 1'b0;
		end
	endtask : strobe
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		expect_now('{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test reset done");
		// stop before write; random byte to both halves
		d = 8'($random(seed));
		wr(1'b1, 1'b1, d);
		wr(1'b1, 1'b0, 8'hAA);
		expect_now('{8'hAA, d, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test write done");
		// prescaler cleared by a write, 2:1 async
		@(posedge sys_clk) ctl <= 8'h17;
		pulse(8'h01, 1'b0);
		wr(1'b1, 1'b1, 8'h10);
		pulse(8'h01, 1'b0);
		expect_now('{8'h10, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0});
		pulse(8'h01, 1'b0);
		expect_now('{8'h11, 8'h10, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test prescaler done");
		// async wrap while asleep, one count past zero
		@(posedge sys_clk) ctl <= 8'h06;
		wr(1'b1, 1'b0, 8'hFE);
		wr(1'b0, 1'b1, 8'hFF);
		@(posedge sys_clk) begin
			ctl <= 8'h07;
			sleep <= 1'b1;
		end
		pulse(8'h03, 1'b0);
		// trigger has no effect unsynchronised, count stays nonzero
		strobe(1'b1);
		expect_now('{8'h01, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0});
		strobe(1'b0);
		expect_now('{8'h01, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test async overflow done");
		// crystal counts in sleep after start-up wait
		@(posedge sys_clk) ctl <= 8'h0F;
		repeat (20) @(posedge sys_clk);
		pulse(8'h03, 1'b1);
		expect_now('{8'h04, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1});
		$display("test crystal done");
		// time base valid synchronised; trigger zeroes count
		@(posedge sys_clk) begin
			ctl <= 8'h03;
			sleep <= 1'b0;
		end
		wr(1'b1, 1'b0, 8'h55);
		strobe(1'b1);
		expect_now('{8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
		// Synchronised pulses count while awake
		pulse(8'h02, 1'b0);
		expect_now('{8'h02, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
		@(posedge sys_clk) sleep <= 1'b1;
		pulse(8'h02, 1'b0);
		expect_now('{8'h02, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
		$display("test sync done");
		// Timer mode: forty clocks give ten instruction ticks at 1:1
		@(posedge sys_clk) begin
			ctl <= 8'h01;
			sleep <= 1'b0;
		end
		repeat (40) @(posedge sys_clk);
		ctl <= 8'h00;
		expect_now('{8'h0C, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test timer done");
		// A reset in mid-run returns the count to zero
		@(posedge sys_clk) rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		expect_now('{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0});
		$display("test mid reset done");
		print_verdict();
	end
endmodule : async_event_counter_timer_tb
